// ==== design/psi_params.svh ====
`ifndef PSI_PARAMS_SVH
`define PSI_PARAMS_SVH

// ----------------------------------------
// device addresses
// ----------------------------------------
`define PSI_DEV_LIVE 5'h07
`define PSI_DEV_VEND 5'h1e

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PSI_ADDR_SNAPSHOT 16'h8030
`define PSI_ADDR_IDENT_HI 16'h0002
`define PSI_ADDR_IDENT_LO 16'h0003
`define PSI_ADDR_PKG1 16'h0005
`define PSI_ADDR_PKG2 16'h0006
`define PSI_ADDR_RESPOND 16'h0008
`define PSI_ADDR_LATCH 16'h0010
`define PSI_ADDR_ENABLE 16'h0020

// ----------------------------------------
// constant and reset values
// ----------------------------------------
`define PSI_PKG1_VAL 16'h008b
`define PSI_PKG2_VAL 16'hc000
`define PSI_RESPOND_VAL 16'h8000
`define PSI_LATCH_RST 16'h1000
`define PSI_ENABLE_RST 16'h1ffe
`define PSI_ENABLE_WR_MASK 16'h1fff
`define PSI_SNAP_RST 5'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define PSI_SNAP_AN_TX 4
`define PSI_SNAP_LEADER 3
`define PSI_SNAP_FOLLOWER 2
`define PSI_SNAP_LVL_HI 1
`define PSI_SNAP_LVL_LO 0
`define PSI_SW_BIT 15
`define PSI_HR_BIT 12
`define PSI_RSVD_MAX 12

`endif

// ==== design/psi_pkg.sv ====
package psi_pkg;

  // one clause 45 register access, already framed
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } psi_req_t;

  // answer to a read
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } psi_rsp_t;

  // live link state from the phy core
  typedef struct packed {
    logic an_ctl_tx;
    logic link_ctl_en;
    logic leader;
    logic tx_lvl_valid;
    logic tx_lvl_high;
  } psi_live_t;

endpackage

// ==== design/psi_live_snap.sv ====
`timescale 1ns/1ps
`include "psi_params.svh"

module psi_live_snap (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // live state
  input psi_pkg::psi_live_t live,
  // registered flags
  output logic [4:0] snap
);
  import psi_pkg::*;

  // ----------------------------------------
  // flag capture
  // ----------------------------------------
  // one flop stage for all flags, so a read sees one instant
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      snap <= `PSI_SNAP_RST;
    end else begin
      snap[`PSI_SNAP_AN_TX] <= live.an_ctl_tx;
      snap[`PSI_SNAP_LEADER] <= live.link_ctl_en & live.leader;
      snap[`PSI_SNAP_FOLLOWER] <= live.link_ctl_en & ~live.leader;
      snap[`PSI_SNAP_LVL_HI] <= live.tx_lvl_valid & live.tx_lvl_high;
      snap[`PSI_SNAP_LVL_LO] <= live.tx_lvl_valid & ~live.tx_lvl_high;
    end
  end

endmodule

// ==== design/psi_irq_latch.sv ====
`timescale 1ns/1ps
`include "psi_params.svh"

module psi_irq_latch #(
  parameter int RSVD_EVENTS = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events
  input wire logic [RSVD_EVENTS-1:0] rsvd_event,
  input wire logic sw_req,
  // register access
  input wire logic clear,
  input wire logic en_wr,
  input wire logic [15:0] en_wdata,
  // state
  output logic [15:0] status,
  output logic [15:0] enable,
  output logic irq
);
  import psi_pkg::*;

  if (RSVD_EVENTS < 1 || RSVD_EVENTS > `PSI_RSVD_MAX) begin : g_bad
    $error("RSVD_EVENTS must be 1 to 12");
  end

  logic [15:0] set_vec;
  logic [15:0] en_eff;
  logic [11:0] rsvd_ext;
  localparam logic [15:0] LATCH_RST = `PSI_LATCH_RST;

  assign rsvd_ext = 12'(rsvd_event);
  assign set_vec = {sw_req, 3'b000, rsvd_ext};

  // ----------------------------------------
  // latched status, one flop per bit
  // ----------------------------------------
  // set beats clear, so an event during the read is kept
  for (genvar i = 0; i < 16; i++) begin : g_bit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        status[i] <= LATCH_RST[i];
      end else if (set_vec[i]) begin
        status[i] <= 1'b1;
      end else if (clear) begin
        status[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // enable register
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enable <= `PSI_ENABLE_RST;
    end else if (en_wr) begin
      enable <= en_wdata & `PSI_ENABLE_WR_MASK;
    end
  end

  // hard reset event stays enabled whatever was written
  // software request is never stored, so it acts as its own enable
  always_comb begin
    en_eff = enable;
    en_eff[`PSI_HR_BIT] = 1'b1;
    en_eff[`PSI_SW_BIT] = 1'b1;
  end

  assign irq = |(status & en_eff);

endmodule

// ==== design/psi_status_regs.sv ====
// What this block does
// - snapshot at device 0x07, rest at 0x1e
// - snapshot bits unlatched, sampled together
// - negotiation-drives-transmitter flag, resets high
// - leader flag when link control enabled
// - follower flag when link control enabled
// - high amplitude flag, resets zero
// - low amplitude flag, resets zero
// - identifier high holds oui bits 3-18
// - identifier low: oui, model, revision
// - first presence register reads 0x008b
// - second presence register reads 0xc000
// - responding status reads binary 10 on top
// - status bits latch until read clears
// - latching ignores the enable mask
// - bit 15 latches software event
// - bit 12 hard reset, set after reset
// - interrupt for enabled latched bits, and always for latched bits 12 and 15
// - software request bit self clears, reads zero
// - hard reset enable resets one, unmaskable
`timescale 1ns/1ps
`include "psi_params.svh"

module psi_status_regs #(
  parameter logic [15:0] OUI_HIGH = 16'h0a5c, // arbitrary value
  parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h03, // arbitrary value
  parameter logic [3:0] REV_NUM = 4'h2, // arbitrary value
  parameter int RSVD_EVENTS = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // management access
  input psi_pkg::psi_req_t req,
  output psi_pkg::psi_rsp_t rsp,
  // phy core state and events
  input psi_pkg::psi_live_t live,
  input wire logic [RSVD_EVENTS-1:0] rsvd_event,
  // interrupt
  output logic irq
);
  import psi_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic on_live;
  logic on_vend;
  logic hit_snap;
  logic hit_id_hi;
  logic hit_id_lo;
  logic hit_pkg1;
  logic hit_pkg2;
  logic hit_resp;
  logic hit_latch;
  logic hit_enable;
  logic latch_clear;
  logic enable_wr;
  logic sw_req;
  logic [4:0] snap;
  logic [15:0] status;
  logic [15:0] enable;
  logic [15:0] rd_mux;
  logic [15:0] ident_low;
  logic [11:0] rsvd_wide;
  psi_rsp_t rsp_reg;
  psi_rsp_t rsp_next;

  assign on_live = req.dev == `PSI_DEV_LIVE;
  assign on_vend = req.dev == `PSI_DEV_VEND;
  assign hit_snap = on_live && req.addr == `PSI_ADDR_SNAPSHOT;
  assign hit_id_hi = on_vend && req.addr == `PSI_ADDR_IDENT_HI;
  assign hit_id_lo = on_vend && req.addr == `PSI_ADDR_IDENT_LO;
  assign hit_pkg1 = on_vend && req.addr == `PSI_ADDR_PKG1;
  assign hit_pkg2 = on_vend && req.addr == `PSI_ADDR_PKG2;
  assign hit_resp = on_vend && req.addr == `PSI_ADDR_RESPOND;
  assign hit_latch = on_vend && req.addr == `PSI_ADDR_LATCH;
  assign hit_enable = on_vend && req.addr == `PSI_ADDR_ENABLE;

  assign ident_low = {OUI_LOW, MODEL_NUM, REV_NUM};
  assign rsvd_wide = 12'(rsvd_event);

  // ----------------------------------------
  // side effects of access
  // ----------------------------------------
  // only the enable register takes writes; all others drop them
  assign enable_wr = req.wr && hit_enable;
  assign sw_req = enable_wr && req.wdata[`PSI_SW_BIT];
  assign latch_clear = req.rd && hit_latch;

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  psi_live_snap u_snap (
    .clock(clock),
    .rst(rst),
    .live(live),
    .snap(snap)
  );

  psi_irq_latch #(
    .RSVD_EVENTS(RSVD_EVENTS)
  ) u_irq (
    .clock(clock),
    .rst(rst),
    .rsvd_event(rsvd_event),
    .sw_req(sw_req),
    .clear(latch_clear),
    .en_wr(enable_wr),
    .en_wdata(req.wdata),
    .status(status),
    .enable(enable),
    .irq(irq)
  );

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_snap) begin
      rd_mux = {11'h000, snap};
    end else if (hit_id_hi) begin
      rd_mux = OUI_HIGH;
    end else if (hit_id_lo) begin
      rd_mux = ident_low;
    end else if (hit_pkg1) begin
      rd_mux = `PSI_PKG1_VAL;
    end else if (hit_pkg2) begin
      rd_mux = `PSI_PKG2_VAL;
    end else if (hit_resp) begin
      rd_mux = `PSI_RESPOND_VAL;
    end else if (hit_latch) begin
      rd_mux = status;
    end else if (hit_enable) begin
      // request bit is self clearing and never stored
      rd_mux = enable;
    end
  end

  always_comb begin
    rsp_next.ack = req.rd;
    rsp_next.rdata = req.rd ? rd_mux : rsp_reg.rdata;
  end

  // data holds until the next read; ack is one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // ----------------------------------------
  // assertion helpers
  // ----------------------------------------
  logic first_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_read_snap;
    req.rd && hit_snap;
  endsequence

  sequence s_quiet_read_latch;
    req.rd && hit_latch && !sw_req && rsvd_event == '0;
  endsequence

  sequence s_sw_write;
    req.wr && hit_enable && req.wdata[`PSI_SW_BIT];
  endsequence

  a_snap_read: assert property (@(posedge clock) disable iff (rst)
    s_read_snap |=> rsp.ack && rsp.rdata == {11'h000, $past(snap)})
    else $error("snapshot read wrong");

  a_an_tx_track: assert property (@(posedge clock) disable iff (rst)
    live.an_ctl_tx |=> snap[`PSI_SNAP_AN_TX])
    else $error("negotiation flag not tracking");

  a_an_tx_idle: assert property (@(posedge clock) disable iff (rst)
    !live.an_ctl_tx |=> !snap[`PSI_SNAP_AN_TX])
    else $error("negotiation flag set while idle");

  a_role_flags: assert property (@(posedge clock) disable iff (rst)
    live.link_ctl_en |=> snap[`PSI_SNAP_LEADER] != snap[`PSI_SNAP_FOLLOWER])
    else $error("role flags not exclusive");

  a_role_value: assert property (@(posedge clock) disable iff (rst)
    live.link_ctl_en |=> snap[`PSI_SNAP_LEADER] == $past(live.leader))
    else $error("role flag does not follow role");

  a_role_idle: assert property (@(posedge clock) disable iff (rst)
    !live.link_ctl_en |=> !snap[`PSI_SNAP_LEADER] && !snap[`PSI_SNAP_FOLLOWER])
    else $error("role flag without link control");

  a_level_flags: assert property (@(posedge clock) disable iff (rst)
    live.tx_lvl_valid |=> snap[`PSI_SNAP_LVL_HI] == $past(live.tx_lvl_high)
      && snap[`PSI_SNAP_LVL_LO] == !$past(live.tx_lvl_high))
    else $error("amplitude flags wrong");

  a_level_idle: assert property (@(posedge clock) disable iff (rst)
    !live.tx_lvl_valid |=> !snap[`PSI_SNAP_LVL_HI] && !snap[`PSI_SNAP_LVL_LO])
    else $error("amplitude flag without known level");

  a_ident_high: assert property (@(posedge clock) disable iff (rst)
    req.rd && hit_id_hi |=> rsp.rdata == OUI_HIGH)
    else $error("identifier high wrong");

  a_ident_low: assert property (@(posedge clock) disable iff (rst)
    req.rd && hit_id_lo |=> rsp.rdata == ident_low)
    else $error("identifier low wrong");

  a_presence_one: assert property (@(posedge clock) disable iff (rst)
    req.rd && hit_pkg1 |=> rsp.rdata == `PSI_PKG1_VAL)
    else $error("first presence wrong");

  a_presence_two: assert property (@(posedge clock) disable iff (rst)
    req.rd && hit_pkg2 |=> rsp.rdata == `PSI_PKG2_VAL)
    else $error("second presence wrong");

  a_responding: assert property (@(posedge clock) disable iff (rst)
    req.rd && hit_resp |=> rsp.rdata[15:14] == 2'b10 && rsp.rdata[13:0] == 14'h0000)
    else $error("responding code wrong");

  a_ack_pulse: assert property (@(posedge clock) disable iff (rst)
    req.rd |=> rsp.ack)
    else $error("read not answered");

  a_ack_idle: assert property (@(posedge clock) disable iff (rst)
    !req.rd |=> !rsp.ack)
    else $error("answer without read");

  a_rdata_holds: assert property (@(posedge clock) disable iff (rst)
    !req.rd |=> rsp.rdata == $past(rsp.rdata))
    else $error("read data changed without read");

  a_read_clears: assert property (@(posedge clock) disable iff (rst)
    s_quiet_read_latch |=> status == 16'h0000
      ##1 (status == 16'h0000 || $past(rsvd_wide) != 12'h000 || $past(sw_req)))
    else $error("status not cleared by read");

  a_irq_clear: assert property (@(posedge clock) disable iff (rst)
    s_quiet_read_latch |=> !irq)
    else $error("interrupt stays after clearing read");

  a_latch_holds: assert property (@(posedge clock) disable iff (rst)
    status[`PSI_SW_BIT] && !latch_clear |=> status[`PSI_SW_BIT])
    else $error("latched bit lost");

  a_latch_masked: assert property (@(posedge clock) disable iff (rst)
    (rsvd_wide & ~enable[11:0]) != 12'h000
      |=> (status[11:0] & $past(rsvd_wide)) == $past(rsvd_wide))
    else $error("masked event not latched");

  a_sw_event: assert property (@(posedge clock) disable iff (rst)
    s_sw_write |=> status[`PSI_SW_BIT] && !enable[`PSI_SW_BIT])
    else $error("software request mishandled");

  a_sw_readback: assert property (@(posedge clock) disable iff (rst)
    req.rd && hit_enable |=> !rsp.rdata[`PSI_SW_BIT])
    else $error("request bit read back set");

  a_enable_write: assert property (@(posedge clock) disable iff (rst)
    req.wr && hit_enable |=> enable == ($past(req.wdata) & `PSI_ENABLE_WR_MASK))
    else $error("enable write not stored");

  a_hr_after_reset: assert property (@(posedge clock) disable iff (rst)
    first_reg |-> status[`PSI_HR_BIT] && irq)
    else $error("hard reset event missing");

  a_hr_unmasked: assert property (@(posedge clock) disable iff (rst)
    status[`PSI_HR_BIT] |-> irq)
    else $error("hard reset interrupt masked");

  a_irq_gate: assert property (@(posedge clock) disable iff (rst)
    irq |-> (status & enable) != 16'h0000 || status[`PSI_HR_BIT] || status[`PSI_SW_BIT])
    else $error("interrupt without enabled cause");

  a_irq_rises: assert property (@(posedge clock) disable iff (rst)
    s_sw_write |=> irq)
    else $error("software request raised no interrupt");

  a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
    req.rd && !(on_live && hit_snap) && !on_vend |=> rsp.rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_ro_write: assert property (@(posedge clock) disable iff (rst)
    req.wr && !hit_enable |=> enable == $past(enable))
    else $error("read-only write changed state");

endmodule

// ==== tb/psi_mgmt_host.sv ====
`timescale 1ns/1ps

module psi_mgmt_host (
  // clock
  input wire logic clock,
  // management port
  output psi_pkg::psi_req_t req,
  input psi_pkg::psi_rsp_t rsp,
  // hard reset request towards the device
  output logic hw_reset_req
);
  import psi_pkg::*;

  // ----------------------------------------
  // request driving
  // ----------------------------------------
  initial begin
    req = '0;
    hw_reset_req = 1'b0;
  end

  // idle fields flip so a stale address never looks valid
  task automatic idle();
    req = {2'b00, ~req.dev, ~req.addr, ~req.wdata};
  endtask

  task automatic do_write(input logic [4:0] dev, input logic [15:0] addr,
                          input logic [15:0] data);
    @(posedge clock);
    #1;
    req = {2'b01, dev, addr, data};
    @(posedge clock);
    #1;
    idle();
  endtask

  // a missing answer comes back as unknown so any compare fails
  task automatic do_read(input logic [4:0] dev, input logic [15:0] addr,
                         output logic [15:0] data);
    @(posedge clock);
    #1;
    req = {2'b10, dev, addr, 16'h0000};
    @(posedge clock);
    #1;
    idle();
    data = rsp.ack ? rsp.rdata : 16'hxxxx;
    if (dev == 5'h1e && addr == 16'h0010 && data[11:0] != 12'h000) begin
      hw_reset_req = 1'b1;
      repeat (2) @(posedge clock);
      #1;
      hw_reset_req = 1'b0;
    end
  endtask
endmodule

// ==== tb/phy_status_id_irq_regs_bench.sv ====
`timescale 1ns/1ps

module phy_status_id_irq_regs_bench;
  import psi_pkg::*;

  // ----------------------------------------
  // setup
  // ----------------------------------------
  localparam logic [15:0] OUI_H = 16'h4d27; // arbitrary value
  localparam logic [5:0] OUI_L = 6'h0b; // arbitrary value
  localparam logic [5:0] MODEL = 6'h26; // arbitrary value
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  localparam logic [4:0] VEND = 5'h1e;
  localparam logic [4:0] LIVE_DEV = 5'h07;

  logic clock = 1'b0;
  logic rst_init = 1'b1;
  wire logic rst;
  psi_req_t req;
  psi_rsp_t rsp;
  psi_live_t live = 5'b10000;
  logic [11:0] rsvd_event = 12'h000;
  logic irq;
  logic hw_reset_req;
  logic [15:0] rd_val;
  int miscompares = 0;
  int cmp_count = 0;
  logic [15:0] reg_addr [6] = '{16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0008,
                                16'h0020};
  logic [15:0] reg_exp [6] = '{OUI_H, {OUI_L, MODEL, REV}, 16'h008b, 16'hc000,
                               16'h8000, 16'h1ffe};
  logic [4:0] snap_in [5] = '{5'b10101, 5'b01111, 5'b01010, 5'b11001, 5'b00110};
  logic [15:0] snap_exp [5] = '{16'h0010, 16'h000a, 16'h0005, 16'h0014, 16'h0001};

  always #50 clock = ~clock;
  assign rst = rst_init | hw_reset_req;

  psi_status_regs #(.OUI_HIGH(OUI_H), .OUI_LOW(OUI_L), .MODEL_NUM(MODEL),
                    .REV_NUM(REV), .RSVD_EVENTS(12)) uut (
    .clock(clock), .rst(rst), .req(req), .rsp(rsp), .live(live),
    .rsvd_event(rsvd_event), .irq(irq));

  psi_mgmt_host host (.clock(clock), .req(req), .rsp(rsp), .hw_reset_req(hw_reset_req));

  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic check_word(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic rd_chk(input logic [4:0] dev, input logic [15:0] addr,
                        input logic [15:0] exp, input string what);
    host.do_read(dev, addr, rd_val);
    check_word(what, exp, rd_val);
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst_init = 1'b0;
    check_flag("irq after reset", 1'b1, irq);
    rd_chk(LIVE_DEV, 16'h8030, 16'h0010, "snapshot reset");
    for (int i = 0; i < 6; i++) begin
      rd_chk(VEND, reg_addr[i], reg_exp[i], "reset value");
    end
    rd_chk(VEND, 16'h0010, 16'h1000, "first status read");
    rd_chk(VEND, 16'h0010, 16'h0000, "status after clear");
    check_flag("irq after clear", 1'b0, irq);
    // read-only, unmapped and wrong-device places
    host.do_write(VEND, 16'h0005, 16'hffff);
    rd_chk(VEND, 16'h0005, 16'h008b, "presence after write");
    rd_chk(VEND, 16'h0040, 16'h0000, "unmapped read");
    rd_chk(VEND, 16'h8030, 16'h0000, "snapshot wrong device");
    // live state needs one cycle to reach the snapshot flop
    for (int i = 0; i < 5; i++) begin
      live = snap_in[i];
      repeat (2) @(posedge clock);
      #1;
      rd_chk(LIVE_DEV, 16'h8030, snap_exp[i], "snapshot");
    end
    host.do_write(VEND, 16'h0020, 16'h8000);
    check_flag("irq software event", 1'b1, irq);
    rd_chk(VEND, 16'h0020, 16'h0000, "enable after request");
    rd_chk(VEND, 16'h0010, 16'h8000, "software event");
    // masked reserved event still latches
    @(posedge clock);
    #1;
    rsvd_event = 12'h008;
    @(posedge clock);
    #1;
    rsvd_event = 12'h000;
    @(posedge clock);
    #1;
    check_flag("irq masked event", 1'b0, irq);
    host.do_write(VEND, 16'h0020, 16'h0008);
    check_flag("irq enabled event", 1'b1, irq);
    rd_chk(VEND, 16'h0010, 16'h0008, "reserved event");
    check_flag("irq after host reset", 1'b1, irq);
    rd_chk(VEND, 16'h0020, 16'h1ffe, "enable after host reset");
    host.do_write(VEND, 16'h0020, 16'h0000);
    check_flag("irq with enable cleared", 1'b1, irq);
    rd_chk(VEND, 16'h0010, 16'h1000, "status after host reset");
    check_flag("irq after final clear", 1'b0, irq);
    end_sim();
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // whole sequence is under a hundred cycles
  initial begin
    repeat (2000) @(posedge clock);
    miscompares++;
    end_sim();
  end
endmodule
